// File: inc/hls_pkg.sv
`default_nettype none

package hls_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int HLS_CHANNELS   = 8;
    localparam int HLS_FIFO_DEPTH = 32;

    // ------------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------------
    // One bipolar symbol: positive mark, negative mark, or space.
    typedef struct packed {
        logic pos;
        logic neg;
    } hls_pair_t;

    localparam int HLS_PAIR_W = $bits(hls_pair_t);

    // Loopback selection of one channel, one-hot.
    typedef enum logic [2:0] {
        HLS_LB_NONE   = 3'h1,
        HLS_LB_REMOTE = 3'h2,
        HLS_LB_ANALOG = 3'h4
    } hls_lb_t;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam hls_pair_t HLS_PAIR_SPACE = 2'h0;
    localparam logic      HLS_BIT_RST    = 1'h0;

endpackage

`default_nettype wire

// File: hdl/hls_loopback_select.sv
// What this block does
// R1 - Hardware mode, select pin low: channel enters remote loopback.
// R2 - Remote loopback ignores the framer's positive and negative data.
// R3 - Outside party keeps the transmit clock running during remote loopback.
// R4 - Outside party may tie the recovered receive clock to transmit clock.
// R5 - Remote loopback resends recovered line data on the line transmit pair.
// R6 - Hardware mode, select pin high: channel enters analog loopback.
// R7 - Analog loopback ignores whatever arrives on the line receive pair.
// R8 - Analog loopback feeds the line transmit output into the receive path.
// R9 - Floating select pin: no loopback, channel runs normally.
// R10 - Host mode with serial control: outside party grounds all select pins.
// R11 - Host mode with parallel control: select pins serve as data bus bits.
// R12 - Each channel follows its own sensed level, independent of the others.
`default_nettype none

// ----------------------------------------------------------------------
// Loopback buffer
// ----------------------------------------------------------------------
module hls_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 32
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rstn_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // Full and empty come straight from the fill count.
    assign in_ready_o  = (count != FULL_CNT) && !flush_i;
    assign out_valid_o = (count != '0) && !flush_i;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_ready_i && out_valid_o;
    assign out_data_o  = mem[rd_ptr];

    // Storage has no reset; only the pointers and the fill count define what is valid.
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers wrap at the configured depth, which need not be a power of two.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (flush_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule

// ----------------------------------------------------------------------
// Per-channel loopback selection
// ----------------------------------------------------------------------
module hls_loopback_select
    import hls_pkg::*;
#(
    parameter int CHANNELS   = HLS_CHANNELS,
    parameter int FIFO_DEPTH = HLS_FIFO_DEPTH
) (
    input  wire logic                sys_clk_i,
    input  wire logic                rstn_i,
    input  wire logic                hw_mode_i,
    input  wire logic                parallel_if_i,
    input  wire logic [CHANNELS-1:0] loopback_select_pin_lo_i,
    input  wire logic [CHANNELS-1:0] loopback_select_pin_hi_i,
    input  wire logic [CHANNELS-1:0] loopback_select_pin_i,
    output logic      [CHANNELS-1:0] loopback_select_pin_o,
    output logic      [CHANNELS-1:0] loopback_select_pin_oe_o,
    input  wire logic [CHANNELS-1:0] cpu_wdata_i,
    input  wire logic                cpu_drive_i,
    output logic      [CHANNELS-1:0] cpu_rdata_o,
    input  wire logic [CHANNELS-1:0] transmit_positive_data_i,
    input  wire logic [CHANNELS-1:0] transmit_negative_data_i,
    input  wire logic [CHANNELS-1:0] transmit_clock_in_i,
    input  wire logic [CHANNELS-1:0] line_receive_pos_i,
    input  wire logic [CHANNELS-1:0] line_receive_neg_i,
    input  wire hls_pair_t [CHANNELS-1:0] rec_data_i,
    input  wire logic [CHANNELS-1:0] rec_valid_i,
    output logic      [CHANNELS-1:0] rec_ready_o,
    output logic      [CHANNELS-1:0] line_transmit_pos_o,
    output logic      [CHANNELS-1:0] line_transmit_neg_o,
    output hls_pair_t [CHANNELS-1:0] rcv_data_o,
    output hls_lb_t   [CHANNELS-1:0] loop_mode_o
);

    // ------------------------------------------------------------------
    // Global strap synchronisers
    // ------------------------------------------------------------------
    logic [1:0] strap_meta;
    logic [1:0] strap_sync;
    logic       hw_mode;
    logic       host_parallel;

    // Mode straps come from pins, so they pass two flops first.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strap_meta <= '0;
            strap_sync <= '0;
        end else begin
            strap_meta <= {hw_mode_i, parallel_if_i};
            strap_sync <= strap_meta;
        end
    end

    assign hw_mode       = strap_sync[1];
    assign host_parallel = !strap_sync[1] && strap_sync[0];

    // ------------------------------------------------------------------
    // Shared data pins in host parallel mode
    // ------------------------------------------------------------------
    // The enable is registered too, so bus and pin direction flip together.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            loopback_select_pin_o    <= '0;
            loopback_select_pin_oe_o <= '0;
        end else begin
            loopback_select_pin_o    <= cpu_wdata_i;               // R11
            loopback_select_pin_oe_o <=
                {CHANNELS{host_parallel && cpu_drive_i}};           // R11
        end
    end

    // ------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
        logic [7:0] pin_meta;
        logic [7:0] pin_sync;
        logic       transmit_clock_in_prev;
        logic       transmit_clock_in_rise;
        logic       sel_lo;
        logic       sel_hi;
        hls_lb_t    mode;
        hls_lb_t    next_mode;
        hls_pair_t  tx;
        hls_pair_t  next_tx;
        hls_pair_t  framer_tx;
        hls_pair_t  line_rx;
        hls_pair_t  fifo_out;
        logic       fifo_valid;
        logic       fifo_pop;
        logic       remote;

        // Every pin of the channel passes two flops before any logic.
        always_ff @(posedge sys_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                pin_meta <= '0;
                pin_sync <= '0;
            end else begin
                pin_meta <= {loopback_select_pin_lo_i[ch],
                             loopback_select_pin_hi_i[ch],
                             loopback_select_pin_i[ch],
                             transmit_positive_data_i[ch],
                             transmit_negative_data_i[ch],
                             transmit_clock_in_i[ch],
                             line_receive_pos_i[ch],
                             line_receive_neg_i[ch]};
                pin_sync <= pin_meta;
            end
        end

        assign sel_lo    = pin_sync[7];
        assign sel_hi    = pin_sync[6];
        assign framer_tx = '{pos: pin_sync[4], neg: pin_sync[3]};
        assign line_rx   = '{pos: pin_sync[1], neg: pin_sync[0]};
        assign transmit_clock_in_rise = pin_sync[2] && !transmit_clock_in_prev;
        assign remote    = (mode == HLS_LB_REMOTE);

        // Edge detection looks only at the settled stage of the clock pin.
        always_ff @(posedge sys_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                transmit_clock_in_prev <= HLS_BIT_RST;
            end else begin
                transmit_clock_in_prev <= pin_sync[2];
            end
        end

        // Three-level decode; both comparators at once is a glitch, so hold.
        always_comb begin
            next_mode = mode;
            if (!hw_mode) begin
                next_mode = HLS_LB_NONE;
            end else if (sel_lo && !sel_hi) begin
                next_mode = HLS_LB_REMOTE;                          // R1
            end else if (sel_hi && !sel_lo) begin
                next_mode = HLS_LB_ANALOG;                          // R6
            end else if (!sel_hi && !sel_lo) begin
                next_mode = HLS_LB_NONE;                            // R9
            end
        end

        // Each channel tracks only its own pin and the shared hardware-mode strap.
        always_ff @(posedge sys_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                mode <= HLS_LB_NONE;
            end else begin
                mode <= next_mode;                                  // R12
            end
        end

        // Recovered data is buffered and drained at the transmit clock rate.
        // Without a running transmit clock the buffer fills and stalls.
        assign fifo_pop = remote && transmit_clock_in_rise;                      // R3

        hls_fifo #(
            .WIDTH (HLS_PAIR_W),
            .DEPTH (FIFO_DEPTH)
        ) u_fifo (
            .sys_clk_i   (sys_clk_i),
            .rstn_i      (rstn_i),
            .flush_i     (!remote),
            .in_valid_i  (rec_valid_i[ch]),
            .in_ready_o  (rec_ready_o[ch]),
            .in_data_i   (rec_data_i[ch]),
            .out_valid_o (fifo_valid),
            .out_ready_i (fifo_pop),
            .out_data_o  (fifo_out)
        );

        // Transmit symbol chosen per mode; both framer marks at once is sent as space, buffer data passes as stored.
        always_comb begin
            next_tx = tx;
            case (mode)
                HLS_LB_REMOTE: begin
                    if (fifo_pop) begin
                        next_tx = fifo_valid ? fifo_out         // R2 R5
                                             : HLS_PAIR_SPACE;
                    end
                end
                HLS_LB_NONE,
                HLS_LB_ANALOG: begin
                    if (transmit_clock_in_rise) begin
                        next_tx = (framer_tx.pos && framer_tx.neg)
                                ? HLS_PAIR_SPACE : framer_tx;
                    end
                end
                default: begin
                    next_tx = HLS_PAIR_SPACE;
                end
            endcase
        end

        // Line driver symbol register.
        always_ff @(posedge sys_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                tx <= HLS_PAIR_SPACE;
            end else begin
                tx <= next_tx;
            end
        end

        // Receive path: analog loopback replaces the line with our own output.
        always_ff @(posedge sys_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                rcv_data_o[ch] <= HLS_PAIR_SPACE;
            end else if (mode == HLS_LB_ANALOG) begin
                rcv_data_o[ch] <= tx;                               // R7 R8
            end else begin
                rcv_data_o[ch] <= line_rx;
            end
        end

        // Read-back of the shared pin for the processor bus.
        always_ff @(posedge sys_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                cpu_rdata_o[ch] <= HLS_BIT_RST;
            end else begin
                cpu_rdata_o[ch] <= pin_sync[5];                     // R11
            end
        end

        assign line_transmit_pos_o[ch] = tx.pos;
        assign line_transmit_neg_o[ch] = tx.neg;
        assign loop_mode_o[ch]         = mode;
    end

endmodule

`default_nettype wire

// File: dv/hls_framer_model.sv
`default_nettype none
module hls_framer_model
    import hls_pkg::*;
#(
    parameter int HALF = 4
) (
    input  wire logic      sys_clk_i,
    input  wire logic      rstn_i,
    input  wire logic      run_i,
    input  wire hls_pair_t sym_i,
    output logic           rise_o,
    output logic     [7:0] transmit_clock_in_o,
    output logic     [7:0] pos_o,
    output logic     [7:0] neg_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // The clock keeps running; a stall parks it low at a period boundary.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= 0;
        end else if (run_i || cnt != 0) begin
            cnt <= (cnt + 1) % (2 * HALF);
        end
    end
    // Data moves half a period away from the rising edge to keep setup.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pos_o <= '0;
            neg_o <= '0;
        end else if (cnt == 0) begin
            pos_o <= {8{sym_i.pos}};
            neg_o <= {8{sym_i.neg}};
        end
    end
    // Clock pin level and a marker for its rising edge.
    // It stands in for a recovered receive clock looped back to the pin.
    assign transmit_clock_in_o = {8{cnt >= HALF}};
    assign rise_o = (cnt == HALF);
endmodule
`default_nettype wire

// File: dv/hls_loopback_select_asserts.sv
`default_nettype none
module hls_loopback_select_asserts
    import hls_pkg::*;
#(
    parameter int CHANNELS = HLS_CHANNELS
) (
    input wire logic                     sys_clk_i,
    input wire logic                     rstn_i,
    input wire logic                     hw_mode_i,
    input wire logic                     parallel_if_i,
    input wire logic                     cpu_drive_i,
    input wire logic      [CHANNELS-1:0] cpu_wdata_i,
    input wire logic      [CHANNELS-1:0] loopback_select_pin_lo_i,
    input wire logic      [CHANNELS-1:0] loopback_select_pin_hi_i,
    input wire logic      [CHANNELS-1:0] loopback_select_pin_o,
    input wire logic      [CHANNELS-1:0] loopback_select_pin_oe_o,
    input wire logic      [CHANNELS-1:0] rec_ready_o,
    input wire logic      [CHANNELS-1:0] line_transmit_pos_o,
    input wire logic      [CHANNELS-1:0] line_transmit_neg_o,
    input wire hls_pair_t [CHANNELS-1:0] rcv_data_o,
    input wire hls_lb_t   [CHANNELS-1:0] loop_mode_o
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [CHANNELS-1:0] lo = loopback_select_pin_lo_i;
    wire logic [CHANNELS-1:0] hi = loopback_select_pin_hi_i;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    // Mode follows a stable pin level after two sync stages and a state flop.
    mode_remote_a: assert property ((hw_mode_i && lo[0] && !hi[0])[*3]
        |=> loop_mode_o[0] == HLS_LB_REMOTE)
        else $error("remote not selected");
    mode_analog_a: assert property ((hw_mode_i && hi[0] && !lo[0])[*3]
        |=> loop_mode_o[0] == HLS_LB_ANALOG)
        else $error("analog not selected");
    mode_none_a: assert property ((hw_mode_i && !lo[0] && !hi[0])[*3] |=>
        loop_mode_o[0] == HLS_LB_NONE) else $error("loopback not cleared");
    chan_indep_a: assert property ((hw_mode_i && hi[1] && !lo[1])[*3] |=>
        loop_mode_o[1] == HLS_LB_ANALOG) else $error("channel one mode");
    host_none_a: assert property ((!hw_mode_i)[*3] |=>
        loop_mode_o[0] == HLS_LB_NONE) else $error("host mode loops");
    // Analog receive path carries the transmit symbol, never the line input.
    rx_analog_a: assert property (
        (loop_mode_o[0] == HLS_LB_ANALOG)[*2] |->
        rcv_data_o[0] == {$past(line_transmit_pos_o[0]),
        $past(line_transmit_neg_o[0])}) else $error("analog receive data");
    ready_remote_a: assert property (rec_ready_o[0] |->
        loop_mode_o[0] == HLS_LB_REMOTE) else $error("buffer ready outside");
    bus_drive_a: assert property ((!hw_mode_i && parallel_if_i)[*3] ##0
        $rose(cpu_drive_i) |=> loopback_select_pin_oe_o == '1 &&
        loopback_select_pin_o == $past(cpu_wdata_i)) else $error("bus drive");
    cover property (loop_mode_o[0] == HLS_LB_REMOTE && rec_ready_o[0]);
    cover property (loop_mode_o[0] == HLS_LB_ANALOG);
    cover property (loopback_select_pin_oe_o[0]);
endmodule
bind hls_loopback_select hls_loopback_select_asserts #(
    .CHANNELS(CHANNELS)
) u_chk (.*);
`default_nettype wire

// File: dv/hls_loopback_select_tb.sv
`default_nettype none
module hls_loopback_select_tb
    import hls_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0, rstn_i = 1'b0, hw_mode_i = 1'b1, run = 1'b1;
    logic parallel_if_i = 1'b0, cpu_drive_i = 1'b0, rise;
    logic [7:0] loopback_select_pin_lo_i = '0, loopback_select_pin_hi_i = '0;
    logic [7:0] pin_ext = '0, cpu_wdata_i = '0, rec_valid_i = '0;
    logic [7:0] line_receive_pos_i = '0, line_receive_neg_i = '0;
    logic [7:0] loopback_select_pin_o, loopback_select_pin_oe_o, cpu_rdata_o;
    logic [7:0] rec_ready_o, line_transmit_pos_o, line_transmit_neg_o;
    logic [7:0] transmit_clock_in_i, transmit_positive_data_i;
    logic [7:0] transmit_negative_data_i;
    hls_pair_t [7:0] rec_data_i = '0;
    hls_pair_t [7:0] rcv_data_o;
    hls_lb_t [7:0] loop_mode_o;
    hls_pair_t sym = 2'h0;
    int failures = 0, n_compared = 0, cycles = 0;
    // The shared pin shows the device's drive while enabled, else the board.
    wire logic [7:0] loopback_select_pin_i = (loopback_select_pin_oe_o &
        loopback_select_pin_o) | (~loopback_select_pin_oe_o & pin_ext);

    hls_loopback_select DUT (.*);
    hls_framer_model FRM (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .run_i(run), .sym_i(sym), .rise_o(rise), .transmit_clock_in_o(transmit_clock_in_i),
        .pos_o(transmit_positive_data_i), .neg_o(transmit_negative_data_i));

    // Clock and a cycle ceiling well above the expected run length.
    always #2.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (failures == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(string name, logic [23:0] got, logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Pin levels change on an edge; the mode settles within four edges.
    task automatic setm(logic [7:0] l, logic [7:0] h, logic hw);
        @(posedge sys_clk_i);
        loopback_select_pin_lo_i <= l;
        loopback_select_pin_hi_i <= h;
        hw_mode_i <= hw;
        repeat (4) @(posedge sys_clk_i);
        #1;
    endtask

    // Lands mid-period after a transmit clock rise, where line data stands.
    task automatic wait_tx();
        do @(posedge sys_clk_i); while (rise !== 1'b1);
        repeat (5) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic t_modes();
        logic [23:0] e;
        e = {{4{HLS_LB_NONE}}, {2{HLS_LB_ANALOG}}, {2{HLS_LB_REMOTE}}};
        setm(8'h03, 8'h0C, 1'b1);
        chk("mode", loop_mode_o, e);
    endtask

    task automatic t_path(logic [7:0] h, hls_pair_t fr, rx, erx);
        setm(8'h00, h, 1'b1);
        @(posedge sys_clk_i);
        sym <= fr;
        line_receive_pos_i <= {8{rx.pos}};
        line_receive_neg_i <= {8{rx.neg}};
        wait_tx();
        wait_tx();
        chk("tx", {line_transmit_pos_o, line_transmit_neg_o},
            {{8{fr.pos}}, {8{fr.neg}}});
        chk("rx", rcv_data_o, {8{erx}});
    endtask

    // Fill the buffer with the framer clock stalled, then drain it.
    task automatic t_remote();
        int k;
        hls_pair_t e;
        k = 0;
        setm(8'hFF, 8'h00, 1'b1);
        @(posedge sys_clk_i);
        sym <= 2'h2;
        run <= 1'b0;
        repeat (12) @(posedge sys_clk_i);
        for (int i = 0; i < 40; i++) begin
            rec_valid_i <= '1;
            rec_data_i <= {8{{1'b0, k[0] ^ k[1]}}};
            @(posedge sys_clk_i);
            if (rec_ready_o[0] === 1'b1) k++;
        end
        rec_valid_i <= '0;
        run <= 1'b1;
        chk("held", k, 32);
        chk("full", rec_ready_o, 8'h00);
        for (int i = 0; i <= 32; i++) begin
            e = (i < 32) ? {1'b0, i[0] ^ i[1]} : 2'h0;
            wait_tx();
            chk("loop", {line_transmit_pos_o, line_transmit_neg_o},
                {{8{e.pos}}, {8{e.neg}}});
        end
        chk("empty", rec_ready_o, 8'hFF);
    endtask

    task automatic t_bus();
        // Serial host mode: the board grounds every select pin.
        setm(8'hFF, 8'h00, 1'b0);
        chk("serial", loop_mode_o, {8{HLS_LB_NONE}});
        @(posedge sys_clk_i);
        parallel_if_i <= 1'b1;
        setm(8'h00, 8'h00, 1'b0);
        chk("host", loop_mode_o, {8{HLS_LB_NONE}});
        @(posedge sys_clk_i);
        cpu_wdata_i <= 8'hA5;
        cpu_drive_i <= 1'b1;
        pin_ext <= 8'h3C;
        repeat (5) @(posedge sys_clk_i);
        #1;
        chk("oe", loopback_select_pin_oe_o, 8'hFF);
        chk("pin", loopback_select_pin_o, 8'hA5);
        chk("rd_own", cpu_rdata_o, 8'hA5);
        @(posedge sys_clk_i);
        cpu_drive_i <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        #1;
        chk("rd_ext", cpu_rdata_o, 8'h3C);
        chk("oe_off", loopback_select_pin_oe_o, 8'h00);
    endtask

    initial begin
        repeat (10) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        t_modes();
        t_path(8'h00, 2'h2, 2'h1, 2'h1);
        t_path(8'hFF, 2'h1, 2'h2, 2'h1);
        t_remote();
        t_bus();
        finish_test();
    end
endmodule
`default_nettype wire
